// *** dv/uepc_ctrl_chk.sv ***
// Port checker for uepc_ctrl.
// Assumes it is bound to the design and sees only the design's ports.
module uepc_ctrl_chk (
   input logic        sys_clk_i,
   input logic        srst_i,
   input logic [7:0]  sfr_addr_i,
   input logic [7:0]  sfr_wdata_i,
   input logic        sfr_wr_i,
   input logic        sfr_rd_i,
   input logic [7:0]  sfr_rdata_o,
   input logic        sfr_hit_o,
   input logic [14:0] ep_status_i,
   input logic [2:0]  ep_fifo_clear_o,
   input logic [2:0]  ep_irq_flag_o,
   input logic        usb_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] en;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   // ==========================================
   // Shadow of the enable register, not a port
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) en <= 3'h0;
      else if (sfr_wr_i && sfr_addr_i == 8'hc2) en <= sfr_wdata_i[2:0];
   end
   property p_rst;
      disable iff (1'b0) srst_i |=> ep_fifo_clear_o == 3'h0 && !usb_irq_o;
   endproperty
   property p_clr;
      sfr_wr_i && sfr_addr_i == 8'hd5
         |=> ep_fifo_clear_o == $past(sfr_wdata_i[2:0]);
   endproperty
   property p_flag;
      1 |=> ep_irq_flag_o == {|$past(ep_status_i[14:10]),
         |$past(ep_status_i[9:5]), |$past(ep_status_i[4:0])};
   endproperty
   property p_irq;
      1 |-> usb_irq_o == |(ep_irq_flag_o & en);
   endproperty
   property p_rdf;
      sfr_rd_i && sfr_addr_i == 8'hf8
         |=> sfr_rdata_o == {5'h00, $past(ep_irq_flag_o)};
   endproperty
   property p_rden;
      sfr_rd_i && sfr_addr_i == 8'hc2 |=> sfr_rdata_o == {5'h00, $past(en)};
   endproperty
   property p_rdrst;
      sfr_rd_i && sfr_addr_i == 8'hd5
         |=> sfr_rdata_o == {5'h00, $past(ep_fifo_clear_o)};
   endproperty
   property p_unmap;
      sfr_rd_i && !(sfr_addr_i inside {8'hc2, 8'hd5, 8'hf8})
         |=> sfr_rdata_o == 8'h00;
   endproperty
   // Hit is combinational from the address alone
   property p_hit;
      1 |-> sfr_hit_o == (sfr_addr_i inside {8'hc2, 8'hd5, 8'hf8});
   endproperty
   a_rst: assert property (p_rst) else $error("clear after reset");
   a_clr: assert property (p_clr) else $error("fifo clear");
   a_flag: assert property (p_flag) else $error("flag");
   a_irq: assert property (p_irq) else $error("irq");
   a_rdf: assert property (p_rdf) else $error("flag read");
   a_rden: assert property (p_rden) else $error("enable read");
   a_rdrst: assert property (p_rdrst) else $error("reset read");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_hit: assert property (p_hit) else $error("address hit");
   c_clr: cover property (ep_fifo_clear_o == 3'h4);
   c_irq: cover property (usb_irq_o);
   c_mask: cover property (ep_irq_flag_o != 3'h0 && !usb_irq_o);
endmodule

// *** dv/uepc_ctrl_tb_top.sv ***
// Self-checking bench for uepc_ctrl.
// Assumes the bench alone drives every design input.
module uepc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 0, srst_i = 1, sfr_wr_i = 0, sfr_rd_i = 0, rd_seen = 0;
   logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, en;
   logic [14:0] ep_status_i = 0, st;
   logic [2:0] ep_fifo_clear_o, ep_irq_flag_o, f;
   logic sfr_hit_o, usb_irq_o;
   logic [7:0] q[$];
   int mismatches = 0, total_checks = 0;
   uepc_ctrl u_dut (.sys_clk_i, .srst_i, .sfr_addr_i, .sfr_wdata_i,
      .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o, .ep_status_i,
      .ep_fifo_clear_o, .ep_irq_flag_o, .usb_irq_o);
   initial forever #20 sys_clk_i = ~sys_clk_i;
   // ==========================================
   // One bus cycle; a read notes its expected byte
   task automatic op(input logic w, input logic [7:0] a, d);
      @(posedge sys_clk_i);
      sfr_wr_i <= w;
      sfr_rd_i <= !w;
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      if (!w) q.push_back(d);
      @(posedge sys_clk_i);
      sfr_wr_i <= 0;
      sfr_rd_i <= 0;
   endtask
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Read data is settled by the falling edge after the strobe
   always @(posedge sys_clk_i) rd_seen <= sfr_rd_i;
   always @(negedge sys_clk_i) begin
      if (rd_seen) chk("rdata", sfr_rdata_o, q.pop_front());
   end
   initial begin
      #100us;
      mismatches++;
      finish_test();
   end
   initial begin
      void'($urandom(74682));
      repeat (4) @(posedge sys_clk_i);
      srst_i <= 0;
      q.delete();
      op(0, 8'hd5, 8'h00);
      op(0, 8'h10, 8'h00);
      // Pulse every FIFO clear before any endpoint is used; reserved
      // bits are never written as ones
      for (int i = 0; i < 3; i++) begin
         op(1, 8'hd5, 8'h1 << i);
         op(0, 8'hd5, 8'h1 << i);
         chk("clear", ep_fifo_clear_o, 8'h1 << i);
         op(1, 8'hd5, 8'h00);
         #1 chk("clear", ep_fifo_clear_o, 8'h00);
      end
      // Each source alone, none, then random mixes under random masks
      for (int j = 0; j < 24; j++) begin
         st = (j < 15) ? 15'h1 << j : (j == 15 ? 15'h0 : $urandom);
         en = $urandom & 8'h07;
         f = {|st[14:10], |st[9:5], |st[4:0]};
         @(posedge sys_clk_i);
         ep_status_i <= st;
         op(1, 8'hc2, en);
         op(1, 8'hf8, 8'h07);
         op(0, 8'hf8, {5'h00, f});
         op(0, 8'hc2, {5'h00, en[2:0]});
         #1 chk("irq", usb_irq_o, |(f & en[2:0]));
      end
      repeat (2) @(posedge sys_clk_i);
      finish_test();
   end
endmodule
bind uepc_ctrl uepc_ctrl_chk u_chk (.sys_clk_i, .srst_i, .sfr_addr_i,
   .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o,
   .ep_status_i, .ep_fifo_clear_o, .ep_irq_flag_o, .usb_irq_o);

// *** verilog/uepc_ctrl.v ***
// Endpoint FIFO reset, interrupt enable and interrupt flag registers.
// Assumes a synchronous SFR bus: one-cycle write and read strobes, and
// read data sampled by the core in the cycle after the read strobe.
//
// Operation
// (R01) Bit two pulse clears endpoint two FIFO
// (R02) Bit one pulse clears endpoint one FIFO
// (R03) Bit zero pulse clears endpoint zero FIFO
// (R04) Firmware pulses FIFO resets before endpoint use
// (R05) Bits seven to three read zero
// (R06) Enable bit two gates endpoint two
// (R07) Enable bit one gates endpoint one
// (R08) Enable bit zero gates endpoint zero
// (R09) FIFO reset register reads zero after reset
// (R10) Flag register is read-only
// (R11) Flag follows OR of endpoint sources
// (R12) Five sources per endpoint flag
// (R13) Request is OR of enabled flags
`include "uepc_defs.vh"

module uepc_ctrl (
   input  wire        sys_clk_i,
   input  wire        srst_i,
   input  wire [7:0]  sfr_addr_i,
   input  wire [7:0]  sfr_wdata_i,
   input  wire        sfr_wr_i,
   input  wire        sfr_rd_i,
   output reg  [7:0]  sfr_rdata_o,
   output wire        sfr_hit_o,
   input  wire [14:0] ep_status_i,
   output wire [2:0]  ep_fifo_clear_o,
   output wire [2:0]  ep_irq_flag_o,
   output wire        usb_irq_o
);

   // ==========================================================
   // Register state
   reg  [2:0] endpoint_fifo_reset_reg;
   reg  [2:0] endpoint_irq_enable_reg;
   wire [2:0] endpoint_irq_flag_reg;
   reg  [7:0] next_rdata;

   // Address decode used by both write and read paths
   function [1:0] uepc_decode;
      input [7:0] addr;
      begin
         if (addr == `UEPC_ADDR_IRQ_ENABLE) begin
            uepc_decode = 2'h1;
         end else if (addr == `UEPC_ADDR_FIFO_RESET) begin
            uepc_decode = 2'h2;
         end else if (addr == `UEPC_ADDR_IRQ_FLAGS) begin
            uepc_decode = 2'h3;
         end else begin
            uepc_decode = 2'h0;
         end
      end
   endfunction

   assign sfr_hit_o = (uepc_decode(sfr_addr_i) != 2'h0);

   // ==========================================================
   // Writable registers
   // Only the low three bits are stored, so ones written to the
   // reserved bits are simply dropped. The flag register has no
   // write path at all.
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         endpoint_fifo_reset_reg <= `UEPC_RST_FIFO_RESET;   // R09
         endpoint_irq_enable_reg <= `UEPC_RST_IRQ_ENABLE;
      end else if (sfr_wr_i) begin
         if (uepc_decode(sfr_addr_i) == 2'h2) begin
            endpoint_fifo_reset_reg <= sfr_wdata_i[`UEPC_EP_MSB:0];
         end else if (uepc_decode(sfr_addr_i) == 2'h1) begin
            endpoint_irq_enable_reg <= sfr_wdata_i[`UEPC_EP_MSB:0];
         end
      end
   end

   // ==========================================================
   // FIFO clear strobes
   // The FIFO is held empty for as long as its bit is one; writing
   // one then zero thus gives the set-and-clear pulse firmware uses
   // after a hardware or bus reset (R04 is firmware's duty).
   assign ep_fifo_clear_o[2] = endpoint_fifo_reset_reg[2];  // R01
   assign ep_fifo_clear_o[1] = endpoint_fifo_reset_reg[1];  // R02
   assign ep_fifo_clear_o[0] = endpoint_fifo_reset_reg[0];  // R03

   // ==========================================================
   // Per-endpoint flags
   genvar ep;
   generate
      for (ep = 0; ep < `UEPC_NUM_EP; ep = ep + 1) begin : g_ep
         uepc_ep_flag u_flag (
            .sys_clk_i (sys_clk_i),
            .srst_i    (srst_i),
            .status_i  (ep_status_i[ep*`UEPC_NUM_SRC +: `UEPC_NUM_SRC]),
            .flag_o    (endpoint_irq_flag_reg[ep])       // R11 R12
         );
      end
   endgenerate

   assign ep_irq_flag_o = endpoint_irq_flag_reg;

   // ==========================================================
   // Interrupt request
   // Masking happens after the flag, so a disabled endpoint still
   // shows its flag to polling firmware.
   assign usb_irq_o =
      (endpoint_irq_flag_reg[2] & endpoint_irq_enable_reg[2]) |  // R06
      (endpoint_irq_flag_reg[1] & endpoint_irq_enable_reg[1]) |  // R07
      (endpoint_irq_flag_reg[0] & endpoint_irq_enable_reg[0]);   // R08 R13

   // ==========================================================
   // Read mux
   always @* begin
      next_rdata = `UEPC_BYTE_ZERO;
      if (uepc_decode(sfr_addr_i) == 2'h1) begin
         next_rdata = {`UEPC_RSVD_ZERO, endpoint_irq_enable_reg};  // R05
      end else if (uepc_decode(sfr_addr_i) == 2'h2) begin
         next_rdata = {`UEPC_RSVD_ZERO, endpoint_fifo_reset_reg};  // R05
      end else if (uepc_decode(sfr_addr_i) == 2'h3) begin
         next_rdata = {`UEPC_RSVD_ZERO, endpoint_irq_flag_reg};    // R10
      end
   end

   // Read data is registered; unmapped addresses read zero
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         sfr_rdata_o <= `UEPC_BYTE_ZERO;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= next_rdata;
      end
   end

endmodule

// *** verilog/uepc_defs.vh ***
// Constants for the endpoint FIFO reset and interrupt enable block.
// Assumes an 8-bit special-function register bus with 8-bit addresses.
`ifndef UEPC_DEFS_VH
`define UEPC_DEFS_VH

// ==========================================================
// Register addresses
`define UEPC_ADDR_IRQ_ENABLE  8'hc2
`define UEPC_ADDR_FIFO_RESET  8'hd5
`define UEPC_ADDR_IRQ_FLAGS   8'hf8

// ==========================================================
// Field layout and reset values
`define UEPC_NUM_EP           3
`define UEPC_NUM_SRC          5
`define UEPC_EP_MSB           2
`define UEPC_RSVD_ZERO        5'h00
`define UEPC_RST_FIFO_RESET   3'h0
`define UEPC_RST_IRQ_ENABLE   3'h0
`define UEPC_BYTE_ZERO        8'h00

// Status source bit positions inside one endpoint's group of five
`define UEPC_SRC_TX_DONE      0
`define UEPC_SRC_OUT_BANK0    1
`define UEPC_SRC_SETUP        2
`define UEPC_SRC_STALL_CRC    3
`define UEPC_SRC_OUT_BANK1    4

`endif

// *** verilog/uepc_ep_flag.v ***
// One endpoint's interrupt flag, gathered from its five status sources.
// Assumes the sources are synchronous levels held by the protocol engine.
`include "uepc_defs.vh"

module uepc_ep_flag (
   input  wire       sys_clk_i,
   input  wire       srst_i,
   input  wire [4:0] status_i,
   output reg        flag_o
);

   // ==========================================================
   // Flag register
   // Registered so the flag register read and the request line agree.
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         flag_o <= 1'b0;
      end else begin
         flag_o <= |status_i;          // R11 R12
      end
   end

endmodule
